// [hdl/cidaf_top.sv]
// Identifier acceptance filter with receive buffer, AHB-Lite registers and interrupt.
`timescale 1ns/1ps
`default_nettype none
`include "cidaf_map.svh"
module cidaf_top
  import cidaf_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // AHB-Lite slave port.
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // Received frames from the protocol receive logic.
  input wire logic i_rx_valid,
  input wire logic [`CIDAF_ID_W-1:0] i_rx_id,
  input wire logic i_rx_ide,
  input wire logic [`CIDAF_DLC_W-1:0] i_rx_dlc,
  input wire logic [`CIDAF_DATA_W-1:0] i_rx_data,
  // Status towards the system.
  output logic o_irq,
  output logic o_init_mode,
  output logic o_rx_accept
);

  // =====================================================================
  // Local declarations.
  localparam int BUF_AW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

  cidaf_regs_s state_reg;
  cidaf_regs_s state_next;

  cidaf_msg_s rx_msg;
  cidaf_msg_s bg_msg;
  logic filt_hit;
  logic [`CIDAF_NUM_BANK-1:0] filt_bank;
  logic addr_phase;
  logic [`CIDAF_IDX_W-1:0] addr_idx;
  logic [BUF_AW-1:0] bg_addr;

  // =====================================================================
  // Decoding of the acceptance code and mask register window.

  // Returns {hit, is_mask, bank, byte}; used by both the read and the write path.
  function automatic logic [4:0] acc_decode(input logic [`CIDAF_IDX_W-1:0] idx);
    logic [4:0] r;
    r = '0;
    if (idx >= `CIDAF_IDX_CODE0 && idx <= `CIDAF_IDX_CODE3) begin
      r = {2'h2, 1'b0, 2'(idx - `CIDAF_IDX_CODE0)};
    end else if (idx >= `CIDAF_IDX_MASK0 && idx <= `CIDAF_IDX_MASK3) begin
      r = {2'h3, 1'b0, 2'(idx - `CIDAF_IDX_MASK0)};
    end else if (idx >= `CIDAF_IDX_CODE4 && idx <= `CIDAF_IDX_CODE7) begin
      r = {2'h2, 1'b1, 2'(idx - `CIDAF_IDX_CODE4)};
    end else if (idx >= `CIDAF_IDX_MASK4 && idx <= `CIDAF_IDX_MASK7) begin
      r = {2'h3, 1'b1, 2'(idx - `CIDAF_IDX_MASK4)};
    end
    return r;
  endfunction

  // Read multiplexer over the current register contents.
  function automatic logic [31:0] read_mux(input cidaf_regs_s s, input logic [`CIDAF_IDX_W-1:0] idx);
    logic [31:0] v;
    logic [4:0] d;
    v = '0;
    d = acc_decode(idx);
    if (d[4]) begin
      // Acceptance bytes read back at any time, in or out of init mode.
      v[`CIDAF_BYTE_W-1:0] = d[3] ? s.mask[d[2:0]] : s.code[d[2:0]];
    end else begin
      case (idx)
        `CIDAF_IDX_CTRL: begin
          v[`CIDAF_CTRL_INIT_REQ] = s.init_req;
        end
        `CIDAF_IDX_STAT: begin
          v[`CIDAF_STAT_INIT_ACK] = s.init_ack;
          v[`CIDAF_STAT_BUSY] = (s.st != CIDAF_ST_IDLE);
        end
        `CIDAF_IDX_EV_STATUS: begin
          v[`CIDAF_EV_W-1:0] = s.ev_status;
        end
        `CIDAF_IDX_EV_ENABLE: begin
          v[`CIDAF_EV_W-1:0] = s.ev_enable;
        end
        `CIDAF_IDX_RX_ID: begin
          v = s.fg.id;
        end
        `CIDAF_IDX_RX_DATA_LO: begin
          v = s.fg.data[31:0];
        end
        `CIDAF_IDX_RX_DATA_HI: begin
          v = s.fg.data[63:32];
        end
        `CIDAF_IDX_RX_INFO: begin
          v = {23'h0, s.fg_bank, 2'h0, s.fg.ide, s.fg.dlc};
        end
        default: begin
          // Unmapped words and the write-only clear register read as zero.
          v = '0;
        end
      endcase
    end
    return v;
  endfunction

  // =====================================================================
  // Background receive buffer and comparison unit.

  // Pack the incoming frame into the buffer word.
  assign rx_msg.ide = i_rx_ide;
  assign rx_msg.dlc = i_rx_dlc;
  assign rx_msg.data = i_rx_data;
  assign rx_msg.id = i_rx_id;
  assign bg_addr = BUF_AW'(`CIDAF_BG_SLOT);

  // Every frame is stored first, whatever the verdict will be; a new frame simply overwrites the slot.
  cidaf_msg_buffer #(
    .W($bits(cidaf_msg_s)),
    .DEPTH(BUF_DEPTH),
    .AW(BUF_AW)
  ) u_buffer (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_wr_en(i_rx_valid),
    .i_wr_addr(bg_addr),
    .i_wr_data(rx_msg),
    .i_rd_en(state_reg.st == CIDAF_ST_READ),
    .i_rd_addr(bg_addr),
    .o_rd_data(bg_msg)
  );

  // The stored message is judged, not the live input, so the verdict matches what software reads.
  cidaf_filter #(
    .NBANK(`CIDAF_NUM_BANK)
  ) u_filter (
    .i_id(bg_msg.id),
    .i_ide(bg_msg.ide),
    .i_code(state_reg.code),
    .i_mask(state_reg.mask),
    .o_hit(filt_hit),
    .o_bank_hit(filt_bank)
  );

  // =====================================================================
  // Bus address phase decode.
  assign addr_phase = i_hsel & i_hready & i_htrans[`CIDAF_HTRANS_ACTIVE];
  assign addr_idx = i_haddr[`CIDAF_WORD_LSB +: `CIDAF_IDX_W];

  // =====================================================================
  // Next-state logic for registers, events and the filter sequencer.
  always_comb begin
    logic [4:0] wd;
    logic [`CIDAF_EV_W-1:0] ev_set;
    logic wr_now;
    wd = '0;
    ev_set = '0;
    wr_now = 1'b0;
    state_next = state_reg;
    state_next.accept_pulse = 1'b0;

    // Capture the address phase; data phase follows with zero wait states.
    state_next.dph_valid = addr_phase;
    state_next.dph_write = i_hwrite;
    state_next.dph_idx = addr_idx;
    if (addr_phase && !i_hwrite) begin
      state_next.hrdata = read_mux(state_reg, addr_idx);
    end

    // Register writes land at the end of the data phase.
    wr_now = state_reg.dph_valid & state_reg.dph_write;
    wd = acc_decode(state_reg.dph_idx);
    if (wr_now) begin
      if (wd[4]) begin
        // Outside init mode the write is silently dropped.
        if (state_reg.init_req && state_reg.init_ack) begin
          if (wd[3]) begin
            state_next.mask[wd[2:0]] = i_hwdata[`CIDAF_BYTE_W-1:0];
          end else begin
            state_next.code[wd[2:0]] = i_hwdata[`CIDAF_BYTE_W-1:0];
          end
        end
      end else begin
        case (state_reg.dph_idx)
          `CIDAF_IDX_CTRL: begin
            state_next.init_req = i_hwdata[`CIDAF_CTRL_INIT_REQ];
          end
          `CIDAF_IDX_EV_CLEAR: begin
            state_next.ev_status = state_reg.ev_status & ~i_hwdata[`CIDAF_EV_W-1:0];
          end
          `CIDAF_IDX_EV_ENABLE: begin
            state_next.ev_enable = i_hwdata[`CIDAF_EV_W-1:0];
          end
          default: begin
          end
        endcase
      end
    end

    // Acknowledge follows the request only between frames, so init mode is never entered mid-decision.
    if (state_reg.st == CIDAF_ST_IDLE) begin
      state_next.init_ack = state_reg.init_req;
    end

    // Filter sequencer: read the background slot, then decide.
    case (state_reg.st)
      CIDAF_ST_IDLE: begin
        state_next.st = CIDAF_ST_IDLE;
      end
      CIDAF_ST_READ: begin
        state_next.st = CIDAF_ST_CHECK;
      end
      CIDAF_ST_CHECK: begin
        state_next.st = CIDAF_ST_IDLE;
        if (filt_hit) begin
          state_next.accept_pulse = 1'b1;
          // Full is judged after this cycle's clear, so a clear racing an accept never loses it.
          if (state_next.ev_status[`CIDAF_EV_ACCEPT]) begin
            ev_set[`CIDAF_EV_OVERRUN] = 1'b1;
          end else begin
            state_next.fg = bg_msg;
            state_next.fg_bank = filt_bank;
            ev_set[`CIDAF_EV_ACCEPT] = 1'b1;
          end
        end else begin
          // Rejected frames leave no trace for software beyond the drop event.
          ev_set[`CIDAF_EV_DROP] = 1'b1;
        end
      end
      default: begin
        state_next.st = CIDAF_ST_IDLE;
      end
    endcase

    // A new frame restarts the sequence; a frame not yet judged is overwritten unsignalled.
    if (i_rx_valid) begin
      state_next.st = CIDAF_ST_READ;
    end

    // Set wins over clear.
    state_next.ev_status = state_next.ev_status | ev_set;
  end

  // =====================================================================
  // State register.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= '0;
      state_reg.st <= CIDAF_ST_IDLE;
      state_reg.code <= {`CIDAF_NUM_ACC{`CIDAF_CODE_RST}};
      state_reg.mask <= {`CIDAF_NUM_ACC{`CIDAF_MASK_RST}};
    end else begin
      state_reg <= state_next;
    end
  end

  // =====================================================================
  // Outputs.

  // Zero wait states; every transfer is answered OKAY, unmapped ones included.
  assign o_hreadyout = 1'b1;
  assign o_hresp = `CIDAF_HRESP_OKAY;
  assign o_hrdata = state_reg.hrdata;

  // Interrupt is a level that stays high while any enabled event is pending.
  assign o_irq = |(state_reg.ev_status & state_reg.ev_enable);
  assign o_init_mode = state_reg.init_req & state_reg.init_ack;
  assign o_rx_accept = state_reg.accept_pulse;

endmodule
`default_nettype wire

// [hdl/cidaf_map.svh]
// Register map, field positions, widths and reset values of the identifier acceptance filter.
`ifndef CIDAF_MAP_SVH
`define CIDAF_MAP_SVH

// =====================================================================
// Register indices; the byte address is four times the index.
`define CIDAF_IDX_W 8
`define CIDAF_WORD_LSB 2
`define CIDAF_IDX_CTRL 8'h00
`define CIDAF_IDX_STAT 8'h01
`define CIDAF_IDX_EV_STATUS 8'h02
`define CIDAF_IDX_EV_CLEAR 8'h03
`define CIDAF_IDX_EV_ENABLE 8'h04
`define CIDAF_IDX_RX_ID 8'h05
`define CIDAF_IDX_RX_DATA_LO 8'h06
`define CIDAF_IDX_RX_DATA_HI 8'h07
`define CIDAF_IDX_RX_INFO 8'h08
`define CIDAF_IDX_CODE0 8'h10
`define CIDAF_IDX_CODE3 8'h13
`define CIDAF_IDX_MASK0 8'h14
`define CIDAF_IDX_MASK3 8'h17
`define CIDAF_IDX_CODE4 8'h18
`define CIDAF_IDX_CODE7 8'h1B
`define CIDAF_IDX_MASK4 8'h1C
`define CIDAF_IDX_MASK7 8'h1F

// =====================================================================
// Fields, event bits and sizes.
`define CIDAF_CTRL_INIT_REQ 0
`define CIDAF_STAT_INIT_ACK 0
`define CIDAF_STAT_BUSY 1
`define CIDAF_EV_ACCEPT 0
`define CIDAF_EV_OVERRUN 1
`define CIDAF_EV_DROP 2
`define CIDAF_EV_W 3
`define CIDAF_BYTE_W 8
`define CIDAF_BANK_BYTES 4
`define CIDAF_STD_BYTES 2
`define CIDAF_NUM_BANK 2
`define CIDAF_NUM_ACC 8
`define CIDAF_ID_W 32
`define CIDAF_DATA_W 64
`define CIDAF_DLC_W 4
`define CIDAF_CODE_RST 8'h00
`define CIDAF_MASK_RST 8'h00
`define CIDAF_BG_SLOT 1'b0
`define CIDAF_HRESP_OKAY 1'b0
`define CIDAF_HTRANS_ACTIVE 1

`endif

// [hdl/cidaf_pkg.sv]
// Types shared by the identifier acceptance filter modules.
`include "cidaf_map.svh"
package cidaf_pkg;

  // =====================================================================
  // Filter sequencer states, one-hot.
  typedef enum logic [2:0] {
    CIDAF_ST_IDLE = 3'h1,
    CIDAF_ST_READ = 3'h2,
    CIDAF_ST_CHECK = 3'h4
  } cidaf_state_e;

  // One received message as it sits in the receive buffer.
  typedef struct packed {
    logic ide;
    logic [`CIDAF_DLC_W-1:0] dlc;
    logic [`CIDAF_DATA_W-1:0] data;
    logic [`CIDAF_ID_W-1:0] id;
  } cidaf_msg_s;

  // Whole state of the top module.
  typedef struct packed {
    cidaf_state_e st;
    logic dph_valid;
    logic dph_write;
    logic [`CIDAF_IDX_W-1:0] dph_idx;
    logic [31:0] hrdata;
    logic init_req;
    logic init_ack;
    logic [`CIDAF_NUM_ACC-1:0][`CIDAF_BYTE_W-1:0] code;
    logic [`CIDAF_NUM_ACC-1:0][`CIDAF_BYTE_W-1:0] mask;
    logic [`CIDAF_EV_W-1:0] ev_status;
    logic [`CIDAF_EV_W-1:0] ev_enable;
    cidaf_msg_s fg;
    logic [`CIDAF_NUM_BANK-1:0] fg_bank;
    logic accept_pulse;
  } cidaf_regs_s;

endpackage

// [hdl/cidaf_msg_buffer.sv]
// Small message memory holding the background receive slot, read data registered.
`timescale 1ns/1ps
`default_nettype none
`include "cidaf_map.svh"
module cidaf_msg_buffer
  import cidaf_pkg::*;
#(
  parameter int W = 8,
  parameter int DEPTH = 2,
  parameter int AW = 1
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_wr_en,
  input wire logic [AW-1:0] i_wr_addr,
  input wire logic [W-1:0] i_wr_data,
  input wire logic i_rd_en,
  input wire logic [AW-1:0] i_rd_addr,
  output logic [W-1:0] o_rd_data
);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [W-1:0] rdata;
  } cidaf_mem_s;

  cidaf_mem_s state_reg;
  cidaf_mem_s state_next;

  // A read in the cycle of a write returns the old word; the caller reads one cycle later.
  always_comb begin
    state_next = state_reg;
    if (i_wr_en) begin
      state_next.mem[i_wr_addr] = i_wr_data;
    end
    if (i_rd_en) begin
      state_next.rdata = state_reg.mem[i_rd_addr];
    end
  end

  // State register.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_rd_data = state_reg.rdata;

endmodule
`default_nettype wire

// [hdl/cidaf_filter.sv]
// Bit-wise identifier comparison against the acceptance code and mask banks.
`timescale 1ns/1ps
`default_nettype none
`include "cidaf_map.svh"
module cidaf_filter
  import cidaf_pkg::*;
#(
  parameter int NBANK = `CIDAF_NUM_BANK
) (
  input wire logic [`CIDAF_ID_W-1:0] i_id,
  input wire logic i_ide,
  input wire logic [NBANK*`CIDAF_BANK_BYTES-1:0][`CIDAF_BYTE_W-1:0] i_code,
  input wire logic [NBANK*`CIDAF_BANK_BYTES-1:0][`CIDAF_BYTE_W-1:0] i_mask,
  output logic o_hit,
  output logic [NBANK-1:0] o_bank_hit
);

  logic [NBANK-1:0][`CIDAF_BANK_BYTES-1:0] byte_ok;

  // A set mask bit means "don't care"; byte 0 is the top byte of the identifier word.
  genvar b;
  genvar k;
  generate
    for (b = 0; b < NBANK; b++) begin : g_bank
      for (k = 0; k < `CIDAF_BANK_BYTES; k++) begin : g_byte
        assign byte_ok[b][k] = ~|((i_id[(`CIDAF_BANK_BYTES-1-k)*`CIDAF_BYTE_W +: `CIDAF_BYTE_W]
                                   ^ i_code[b*`CIDAF_BANK_BYTES+k])
                                  & ~i_mask[b*`CIDAF_BANK_BYTES+k]);
      end
      // Standard frames ignore the last two bytes of the bank entirely.
      assign o_bank_hit[b] = i_ide ? &byte_ok[b] : &byte_ok[b][`CIDAF_STD_BYTES-1:0];
    end
  endgenerate

  // Either bank may accept the message.
  assign o_hit = |o_bank_hit;

endmodule
`default_nettype wire

// [bench/cidaf_chk.sv]
// Checker on the acceptance filter top ports, bound at the foot.
`timescale 1ns/1ps
`default_nettype none
module cidaf_chk (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic i_rx_valid,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic [31:0] o_hrdata,
  input wire logic o_irq,
  input wire logic o_init_mode,
  input wire logic o_rx_accept
);
  // ==========
  // Helpers
  logic taken;
  logic wr_dph_reg;
  logic rd_dph_reg;
  // A transfer is taken on a selected, ready, active address phase.
  assign taken = i_hsel & i_hready & i_htrans[1];
  // Data phase flags; read data may change only behind a read, and init mode and the interrupt may fall only behind a write.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_dph_reg <= 1'b0;
      rd_dph_reg <= 1'b0;
    end else begin
      wr_dph_reg <= taken & i_hwrite;
      rd_dph_reg <= taken & ~i_hwrite;
    end
  end
  // ==========
  // Properties
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  a_ready_high: assert property (o_hreadyout == 1'b1)
    else $error("hreadyout low");
  a_resp_okay: assert property (o_hresp == 1'b0)
    else $error("error response");
  a_rdata_hold: assert property (!rd_dph_reg |-> $stable(o_hrdata))
    else $error("read data moved without a read");
  a_init_exit: assert property ($fell(o_init_mode) |-> $past(wr_dph_reg))
    else $error("init mode left without a write");
  a_accept_lat: assert property (o_rx_accept |-> $past(i_rx_valid, 3))
    else $error("accept without frame three edges back");
  a_accept_pulse: assert property (o_rx_accept |=> !o_rx_accept)
    else $error("accept longer than one cycle");
  a_irq_cause: assert property ($rose(o_irq) |-> $past(wr_dph_reg) || $past(i_rx_valid, 3))
    else $error("interrupt rose without cause");
  a_irq_clear: assert property ($fell(o_irq) |-> $past(wr_dph_reg))
    else $error("interrupt fell without a write");
endmodule
bind cidaf_top cidaf_chk u_chk (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_hsel(i_hsel), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
  .i_hready(i_hready), .i_rx_valid(i_rx_valid), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
  .o_hrdata(o_hrdata), .o_irq(o_irq), .o_init_mode(o_init_mode), .o_rx_accept(o_rx_accept)
);
`default_nettype wire

// [bench/cidaf_rx_model.sv]
// Behavioural model of the protocol receive logic that hands frames over.
`timescale 1ns/1ps
`default_nettype none
`include "cidaf_map.svh"
module cidaf_rx_model (
  input wire logic i_sys_clk,
  output logic o_rx_valid,
  output logic [`CIDAF_ID_W-1:0] o_rx_id,
  output logic o_rx_ide,
  output logic [`CIDAF_DLC_W-1:0] o_rx_dlc,
  output logic [`CIDAF_DATA_W-1:0] o_rx_data
);
  // Lines start idle with a pattern of ones.
  initial begin
    o_rx_valid = 1'b0;
    o_rx_id = 32'hFFFFFFFF;
    o_rx_ide = 1'b1;
    o_rx_dlc = 4'hF;
    o_rx_data = 64'hFFFFFFFFFFFFFFFF;
  end
  // One frame for one cycle; afterwards the lines are inverted so stale data never looks fresh.
  task automatic send(input logic [31:0] id, input logic ide);
    @(posedge i_sys_clk);
    o_rx_valid <= 1'b1;
    o_rx_id <= id;
    o_rx_ide <= ide;
    o_rx_dlc <= 4'h8;
    o_rx_data <= {~id, id};
    @(posedge i_sys_clk);
    o_rx_valid <= 1'b0;
    o_rx_id <= ~id;
    o_rx_ide <= ~ide;
    o_rx_dlc <= 4'h7;
    o_rx_data <= {id, ~id};
  endtask
endmodule
`default_nettype wire

// [bench/cidaf_top_test.sv]
// Self-checking testbench of the identifier acceptance filter.
`timescale 1ns/1ps
`default_nettype none
`include "cidaf_map.svh"
module cidaf_top_test;
  // ==========
  // Signals and tables
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b1;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rx_id;
  logic [63:0] rx_data;
  logic [3:0] rx_dlc;
  logic hready, hresp, irq, init_mode, rx_accept, rx_valid, rx_ide;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  // Codes and masks; bank 0 leaves bit 0 of its second byte free.
  logic [7:0] code [8] = '{8'h12, 8'h34, 8'h56, 8'h78, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  logic [7:0] mask [8] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // Frames; bit i of the masks below is the kind (1 extended) and verdict of frame i.
  logic [31:0] ids [8] = '{32'h12345678, 32'h12355678, 32'h12345679, 32'h92345678,
    32'h1234AAAA, 32'h12360000, 32'hFFFFFFFF, 32'hFFFF0000};
  logic [7:0] ides = 8'h4F;
  logic [7:0] accs = 8'hD3;
  // Free-running 100 MHz clock.
  initial begin
    forever #5 clk = ~clk;
  end
  cidaf_top u_dut (
    .i_sys_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp),
    .o_hrdata(hrdata), .i_rx_valid(rx_valid), .i_rx_id(rx_id), .i_rx_ide(rx_ide), .i_rx_dlc(rx_dlc),
    .i_rx_data(rx_data), .o_irq(irq), .o_init_mode(init_mode), .o_rx_accept(rx_accept)
  );
  cidaf_rx_model u_src (
    .i_sys_clk(clk), .o_rx_valid(rx_valid), .o_rx_id(rx_id), .o_rx_ide(rx_ide), .o_rx_dlc(rx_dlc),
    .o_rx_data(rx_data)
  );
  // ==========
  // Helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One single word transfer; the master waits for ready at both phase ends.
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    // Stale write data is inverted, so a slave that samples it too early, in the address phase, reads a wrong word.
    hwdata <= ~hwdata;
    htrans <= 2'h2;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, idx, d, x);
  endtask
  task automatic rdc(input string what, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, idx, 32'h0, x);
    check(what, x, exp);
  endtask
  // Word index of code byte i, or of mask byte i when m is set.
  function automatic logic [7:0] cidx(input int i, input logic m);
    return 8'(i < 4 ? 32'h10 + i : 32'h14 + i) + (m ? 8'h4 : 8'h0);
  endfunction
  // ==========
  // Scenarios
  task automatic test_reset;
    for (int i = 0; i < 8; i++) begin
      rdc("code rst", cidx(i, 1'b0), 32'h0);
      rdc("mask rst", cidx(i, 1'b1), 32'h0);
    end
    wr(8'h3F, 32'h5A);
    rdc("unmapped", 8'h3F, 32'h0);
    rdc("events", `CIDAF_IDX_EV_STATUS, 32'h0);
    check("irq", irq, 1'b0);
    check("hresp", hresp, 1'b0);
    $display("test_reset done");
  endtask
  // Writes outside init mode are dropped; inside it they land.
  task automatic test_init;
    wr(`CIDAF_IDX_CODE0, 32'hA5);
    rdc("locked", `CIDAF_IDX_CODE0, 32'h0);
    wr(`CIDAF_IDX_CTRL, 32'h1);
    rdc("init ack", `CIDAF_IDX_STAT, 32'h1);
    check("init mode", init_mode, 1'b1);
    for (int i = 0; i < 8; i++) begin
      wr(cidx(i, 1'b0), {24'h0, code[i]});
      wr(cidx(i, 1'b1), {24'h0, mask[i]});
    end
    for (int i = 0; i < 8; i++) begin
      rdc("code", cidx(i, 1'b0), {24'h0, code[i]});
    end
    wr(`CIDAF_IDX_CTRL, 32'h0);
    wr(`CIDAF_IDX_CODE0, 32'h0);
    rdc("kept", `CIDAF_IDX_CODE0, 32'h12);
    check("init left", init_mode, 1'b0);
    $display("test_init done");
  endtask
  // Each frame is judged; rejected ones leave the received identifier alone.
  task automatic test_frames;
    logic [31:0] last;
    last = 32'h0;
    wr(`CIDAF_IDX_EV_ENABLE, 32'h7);
    for (int i = 0; i < 8; i++) begin
      u_src.send(ids[i], ides[i]);
      repeat (2) @(posedge clk);
      #1 check("accept", rx_accept, accs[i]);
      check("irq set", irq, 1'b1);
      if (accs[i]) last = ids[i];
      rdc("events", `CIDAF_IDX_EV_STATUS, accs[i] ? 32'h1 : 32'h4);
      rdc("rx id", `CIDAF_IDX_RX_ID, last);
      rdc("rx data lo", `CIDAF_IDX_RX_DATA_LO, last);
      rdc("rx data hi", `CIDAF_IDX_RX_DATA_HI, ~last);
      wr(`CIDAF_IDX_EV_CLEAR, 32'h7);
      #1 check("irq clr", irq, 1'b0);
    end
    $display("test_frames done");
  endtask
  // Masked events keep the line low; an overrun keeps the first frame.
  task automatic test_irq;
    wr(`CIDAF_IDX_EV_ENABLE, 32'h0);
    for (int i = 0; i < 2; i++) begin
      u_src.send(ids[6 * i], 1'b1);
      repeat (2) @(posedge clk);
      #1 check("irq masked", irq, 1'b0);
    end
    rdc("overrun", `CIDAF_IDX_EV_STATUS, 32'h3);
    rdc("first kept", `CIDAF_IDX_RX_ID, ids[0]);
    wr(`CIDAF_IDX_EV_ENABLE, 32'h2);
    #1 check("irq on", irq, 1'b1);
    wr(`CIDAF_IDX_EV_CLEAR, 32'h2);
    #1 check("irq off", irq, 1'b0);
    $display("test_irq done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // A hang counts as a mismatch and ends the run.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      stop_test();
    end
  end
  // Reset for four cycles, then the scenarios in turn.
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    test_reset();
    test_init();
    test_frames();
    test_irq();
    stop_test();
  end
endmodule
`default_nettype wire
